// File: hw/led_pwm_params.svh
// Register indices, field positions, reset values and timing figures for the LED/PWM block.
`ifndef LED_PWM_PARAMS_SVH
`define LED_PWM_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_LED_INTERVAL 8'h6c
`define IDX_LED_SHAPE 8'h6d
`define IDX_PWM_RATE_SELECT 8'h6e
`define IDX_PWM_DUTY 8'h6f
`define IDX_SCRATCH 8'h70
`define IDX_REVISION 8'h80
`define IDX_GPIO_ROUTE 8'h60

// Field positions.
`define LED_A_WIDTH_LSB 0
`define LED_B_WIDTH_LSB 2
`define LED_A_DOUBLE_BIT 4
`define LED_B_DOUBLE_BIT 5
`define LED_A_INTERVAL_LSB 0
`define LED_B_INTERVAL_LSB 3
`define REV_BOOT_READ_BIT 7
`define GPIO_LEVEL_BIT 0
`define GPIO_DIR_BIT 1
`define GPIO_PWM_SEL_BIT 2

// Reset values.
`define RST_BYTE 8'h00
`define RST_CODE2 2'h0

// Timing figures as printed, and the clock they are counted in.
`define CLK_PERIOD_NS 10
`define LED_TICK_US 62500
`define PWM_BASE_HZ 500
`define PWM_SLOTS 256

`endif

// File: hw/led_pwm_pkg.sv
// Shared types for the LED pulse and PWM block.
package led_pwm_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [1:0] code2_t;
  typedef logic [2:0] interval_code_t;
  typedef logic [6:0] tick_count_t;
endpackage

// File: hw/led_pulse_channel.sv
// One LED channel: single or double on/off pulses repeated every interval.
`timescale 1ns/1ps
`include "led_pwm_params.svh"
module led_pulse_channel
  import led_pwm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic gen_clear,
  input wire logic tick,
  input wire interval_code_t interval_code,
  input wire code2_t width_code,
  input wire logic double_pulse,
  output logic led_q
);

  tick_count_t phase_q;
  tick_count_t phase_d;
  logic led_d;
  logic [7:0] on_len;
  logic [7:0] last_tick;
  logic [7:0] phase_w;

  // Lengths in 62.5 ms ticks; the interval is 2^code ticks, so code 1 is 125 ms.
  assign on_len = 8'h01 << width_code;
  assign last_tick = (8'h01 << interval_code) - 8'h01;
  assign phase_w = {1'b0, phase_q};

  // Phase counter and pulse shaping; an on time longer than the interval is cut at the wrap.
  always_comb
  begin
    phase_d = phase_q;
    led_d = 1'b0;
    if (gen_clear || interval_code == 3'h0)
    begin
      phase_d = '0;
    end
    else
    begin
      if (tick)
      begin
        if (phase_w >= last_tick)
        begin
          phase_d = '0;
        end
        else
        begin
          phase_d = phase_q + 7'h01;
        end
      end
      // RULE_02: single pulse
      led_d = (phase_w < on_len);
      // RULE_01: second pulse
      if (double_pulse && phase_w >= (on_len << 1) && phase_w < (on_len * 8'h03))
      begin
        led_d = 1'b1;
      end
    end
  end

  // Channel state registers.
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      phase_q <= '0;
      led_q <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      led_q <= led_d;
    end
  end

endmodule

// File: hw/led_pwm_regs.sv
// Avalon-MM register block driving two LED pulse outputs, a PWM output and a GPIO pin.
//
// Functional notes
// RULE_01: Double-pulse bit 1: on, off, on, each one on time, then off.
// RULE_02: Double-pulse bit 0: one on-time pulse per period, then off.
// RULE_03: Two-bit on time per LED: 62.5, 125, 250 or 500 ms.
// RULE_04: Two-bit PWM rate code selects 500, 250, 125 or 62.5 Hz.
// RULE_05: Eight-bit duty sets high fraction as code over 256.
// RULE_06: LED and PWM registers clear to zero on general reset.
// RULE_07: Eight-bit spare register, no effect, cleared only by full reset.
// RULE_08: Revision bit 7 enables boot mode read for scan test; resets 0.
// RULE_09: Revision bits 3:0 fixed read-only code; bits 6:4 read zero.
// RULE_10: Three-bit LED interval: 000 off, else 0.125 s doubling to 8 s.
// RULE_11: Output GPIO carries its level or PWM, select bit 1 means PWM.
// RULE_12: PWM high for first duty slots of 256; settings change at period end.
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
`include "led_pwm_params.svh"
module led_pwm_regs
  import led_pwm_pkg::*;
#(
  parameter int LED_TICK_CYC = (`LED_TICK_US * 1000) / `CLK_PERIOD_NS,
  parameter int PWM_SLOT_CYC = (1000000000 / (`PWM_BASE_HZ * `PWM_SLOTS)) / `CLK_PERIOD_NS,
  parameter logic [3:0] REVISION_CODE = 4'h5 // Arbitrary value.
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic gen_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic led_a_q,
  output logic led_b_q,
  output logic pwm_q,
  output logic gpio_out_q,
  output logic gpio_oe_n_q,
  output logic boot_read_en_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  logic waitrequest_q;
  logic waitrequest_d;
  logic [31:0] readdata_q;
  logic [31:0] readdata_d;
  logic wr_take;
  reg_byte_t rd_byte;

  reg_byte_t interval_q, interval_d;
  reg_byte_t shape_q, shape_d;
  code2_t freq_q, freq_d;
  reg_byte_t duty_q, duty_d;
  reg_byte_t scratch_q, scratch_d;
  logic boot_rd_q, boot_rd_d;
  logic [2:0] gpio_q, gpio_d;

  assign avs_waitrequest = waitrequest_q;
  assign avs_readdata = readdata_q;
  assign boot_read_en_q = boot_rd_q;

  // A write lands on the edge where the master sees waitrequest low.
  assign wr_take = avs_write && !waitrequest_q && avs_byteenable[0];

  // Read multiplexer; unmapped indices and reserved bits read as zero.
  always_comb
  begin
    rd_byte = 8'h00;
    if (avs_address == `IDX_LED_INTERVAL)
    begin
      rd_byte = {2'b00, interval_q[5:0]};
    end
    else if (avs_address == `IDX_LED_SHAPE)
    begin
      rd_byte = {2'b00, shape_q[5:0]};
    end
    else if (avs_address == `IDX_PWM_RATE_SELECT)
    begin
      rd_byte = {6'h00, freq_q};
    end
    else if (avs_address == `IDX_PWM_DUTY)
    begin
      rd_byte = duty_q;
    end
    else if (avs_address == `IDX_SCRATCH)
    begin
      rd_byte = scratch_q;
    end
    else if (avs_address == `IDX_REVISION)
    begin
      // RULE_09: fixed revision code
      rd_byte = {boot_rd_q, 3'b000, REVISION_CODE};
    end
    else if (avs_address == `IDX_GPIO_ROUTE)
    begin
      rd_byte = {5'h00, gpio_q};
    end
  end

  // Handshake: waitrequest drops for exactly one cycle per request.
  always_comb
  begin
    waitrequest_d = 1'b1;
    readdata_d = readdata_q;
    if ((avs_read || avs_write) && waitrequest_q)
    begin
      waitrequest_d = 1'b0;
      readdata_d = {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      waitrequest_q <= 1'b1;
      readdata_q <= 32'h00000000;
    end
    else
    begin
      waitrequest_q <= waitrequest_d;
      readdata_q <= readdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  // General-domain registers also clear on gen_rst; the full-domain ones only on sys_rst.
  always_comb
  begin
    interval_d = interval_q;
    shape_d = shape_q;
    freq_d = freq_q;
    duty_d = duty_q;
    gpio_d = gpio_q;
    scratch_d = scratch_q;
    boot_rd_d = boot_rd_q;
    if (wr_take)
    begin
      if (avs_address == `IDX_LED_INTERVAL)
      begin
        interval_d = {2'b00, avs_writedata[5:0]};
      end
      else if (avs_address == `IDX_LED_SHAPE)
      begin
        shape_d = {2'b00, avs_writedata[5:0]};
      end
      else if (avs_address == `IDX_PWM_RATE_SELECT)
      begin
        freq_d = avs_writedata[1:0];
      end
      else if (avs_address == `IDX_PWM_DUTY)
      begin
        duty_d = avs_writedata[7:0];
      end
      else if (avs_address == `IDX_SCRATCH)
      begin
        // RULE_07: spare storage
        scratch_d = avs_writedata[7:0];
      end
      else if (avs_address == `IDX_REVISION)
      begin
        // RULE_08: boot read enable
        boot_rd_d = avs_writedata[`REV_BOOT_READ_BIT];
      end
      else if (avs_address == `IDX_GPIO_ROUTE)
      begin
        gpio_d = avs_writedata[2:0];
      end
    end
    // RULE_06: general reset clear
    if (gen_rst)
    begin
      interval_d = `RST_BYTE;
      shape_d = `RST_BYTE;
      freq_d = `RST_CODE2;
      duty_d = `RST_BYTE;
      gpio_d = 3'h0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      interval_q <= `RST_BYTE;
      shape_q <= `RST_BYTE;
      freq_q <= `RST_CODE2;
      duty_q <= `RST_BYTE;
      gpio_q <= 3'h0;
      scratch_q <= `RST_BYTE;
      boot_rd_q <= 1'b0;
    end
    else
    begin
      interval_q <= interval_d;
      shape_q <= shape_d;
      freq_q <= freq_d;
      duty_q <= duty_d;
      gpio_q <= gpio_d;
      scratch_q <= scratch_d;
      boot_rd_q <= boot_rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // LED tick divider and channels.

  logic [31:0] led_div_q, led_div_d;
  logic led_tick_q, led_tick_d;

  // One 62.5 ms enable pulse shared by both channels.
  always_comb
  begin
    led_div_d = led_div_q + 32'h1;
    led_tick_d = 1'b0;
    if (gen_rst)
    begin
      led_div_d = 32'h0;
    end
    else if (led_div_q >= 32'(LED_TICK_CYC - 1))
    begin
      led_div_d = 32'h0;
      led_tick_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      led_div_q <= 32'h0;
      led_tick_q <= 1'b0;
    end
    else
    begin
      led_div_q <= led_div_d;
      led_tick_q <= led_tick_d;
    end
  end

  // RULE_10: interval codes
  // RULE_03: on-time codes
  led_pulse_channel u_led_a (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .gen_clear(gen_rst),
    .tick(led_tick_q),
    .interval_code(interval_q[`LED_A_INTERVAL_LSB +: 3]),
    .width_code(shape_q[`LED_A_WIDTH_LSB +: 2]),
    .double_pulse(shape_q[`LED_A_DOUBLE_BIT]),
    .led_q(led_a_q)
  );

  led_pulse_channel u_led_b (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .gen_clear(gen_rst),
    .tick(led_tick_q),
    .interval_code(interval_q[`LED_B_INTERVAL_LSB +: 3]),
    .width_code(shape_q[`LED_B_WIDTH_LSB +: 2]),
    .double_pulse(shape_q[`LED_B_DOUBLE_BIT]),
    .led_q(led_b_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // PWM generator.

  // Slot length truncates to whole cycles, so 500 Hz runs slightly fast.
  localparam logic [15:0] SLOT_BASE = 16'(PWM_SLOT_CYC);

  logic [15:0] pre_q, pre_d;
  logic [7:0] slot_q, slot_d;
  reg_byte_t duty_live_q, duty_live_d;
  code2_t freq_live_q, freq_live_d;
  logic pwm_d;
  logic [15:0] slot_len;

  // RULE_04: rate doubles slot length
  assign slot_len = SLOT_BASE << freq_live_q;

  always_comb
  begin
    pre_d = pre_q + 16'h1;
    slot_d = slot_q;
    duty_live_d = duty_live_q;
    freq_live_d = freq_live_q;
    if (pre_q >= slot_len - 16'h1)
    begin
      pre_d = 16'h0;
      slot_d = slot_q + 8'h01;
      // RULE_12: latch at period end
      if (slot_q == 8'hff)
      begin
        duty_live_d = duty_q;
        freq_live_d = freq_q;
      end
    end
    if (gen_rst)
    begin
      pre_d = 16'h0;
      slot_d = 8'h00;
      duty_live_d = `RST_BYTE;
      freq_live_d = `RST_CODE2;
    end
    // RULE_05: duty over 256
    pwm_d = (slot_q < duty_live_q);
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pre_q <= 16'h0;
      slot_q <= 8'h00;
      duty_live_q <= `RST_BYTE;
      freq_live_q <= `RST_CODE2;
      pwm_q <= 1'b0;
    end
    else
    begin
      pre_q <= pre_d;
      slot_q <= slot_d;
      duty_live_q <= duty_live_d;
      freq_live_q <= freq_live_d;
      pwm_q <= pwm_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // GPIO pin routing.

  logic gpio_out_d;
  logic gpio_oe_n_d;

  // RULE_11: level or PWM
  always_comb
  begin
    gpio_out_d = gpio_q[`GPIO_PWM_SEL_BIT] ? pwm_q : gpio_q[`GPIO_LEVEL_BIT];
    gpio_oe_n_d = !gpio_q[`GPIO_DIR_BIT];
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gpio_out_q <= 1'b0;
      gpio_oe_n_q <= 1'b1;
    end
    else
    begin
      gpio_out_q <= gpio_out_d;
      gpio_oe_n_q <= gpio_oe_n_d;
    end
  end

endmodule

// File: tb/led_pwm_regs_chk.sv
// Checker for bus timing, read fields and general reset effects of the LED/PWM block.
`timescale 1ns/1ps
`include "led_pwm_params.svh"
module led_pwm_regs_chk
#(
  parameter logic [3:0] REVISION_CODE = 4'h5
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic gen_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic led_a_q,
  input wire logic led_b_q,
  input wire logic gpio_oe_n_q,
  input wire logic boot_read_en_q
);
  // One clock domain; a full reset voids every check.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake and read data.
  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in the next cycle");
  a_rdata_hold: assert property ($changed(avs_readdata) |-> !avs_waitrequest)
    else $error("read data changed outside a read answer");
  a_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_rev_fields: assert property (avs_read && !avs_waitrequest && avs_address == `IDX_REVISION
    |-> avs_readdata[6:0] == {3'b000, REVISION_CODE})
    else $error("revision code or reserved bits wrong");
  ////////////////////////////////////////////////////////////////////////////
  // General reset clears LED and pin state but spares the boot read enable.
  a_boot_keep: assert property (gen_rst |=> $stable(boot_read_en_q))
    else $error("boot read enable touched by general reset");
  a_led_gen_off: assert property (gen_rst |=> ##1 !(led_a_q || led_b_q))
    else $error("LED still on after general reset");
  a_oe_gen_off: assert property (gen_rst |=> ##1 gpio_oe_n_q)
    else $error("pin still driven after general reset");
  c_gen: cover property (gen_rst);
  c_led: cover property ($rose(led_a_q));
  c_wr: cover property (avs_write && !avs_waitrequest);
endmodule

bind led_pwm_regs led_pwm_regs_chk #(.REVISION_CODE(REVISION_CODE)) led_pwm_regs_chk_inst (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .gen_rst(gen_rst),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .led_a_q(led_a_q),
  .led_b_q(led_b_q),
  .gpio_oe_n_q(gpio_oe_n_q),
  .boot_read_en_q(boot_read_en_q)
);

// File: tb/led_pwm_regs_test.sv
// Self-checking bench for the LED pulse and PWM register block.
`timescale 1ns/1ps
`include "led_pwm_params.svh"
module led_pwm_regs_test
  import led_pwm_pkg::*;
;
  localparam int TICK = 8;
  localparam int PWM_SLOT = 2;
  localparam logic [3:0] REV = 4'h5; // Arbitrary value.
  localparam logic [7:0] IDX [4] = '{`IDX_LED_SHAPE, `IDX_PWM_RATE_SELECT, `IDX_PWM_DUTY, `IDX_SCRATCH};
  localparam logic [7:0] MSK [4] = '{8'h3f, 8'h03, 8'hff, 8'hff};
  logic sys_clk, sys_rst = 1'b1, gen_rst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'h0;
  logic avs_waitrequest, led_a_q, led_b_q, pwm_q, gpio_out_q, gpio_oe_n_q, boot_read_en_q;
  int err_count = 0, n_compared = 0, seed = 87893, ha, hb, ra, rb;
  logic [31:0] exp_q [$];
  reg_byte_t val [4];

  led_pwm_regs #(
    .LED_TICK_CYC(TICK),
    .PWM_SLOT_CYC(PWM_SLOT),
    .REVISION_CODE(REV)
  ) led_pwm_regs_inst (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .gen_rst(gen_rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .led_a_q(led_a_q),
    .led_b_q(led_b_q),
    .pwm_q(pwm_q),
    .gpio_out_q(gpio_out_q),
    .gpio_oe_n_q(gpio_oe_n_q),
    .boot_read_en_q(boot_read_en_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock, verdict and shared tasks.
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task complete_run;
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task check_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The request is held until waitrequest is seen low at an edge.
  task bus_wr(input logic [7:0] a, input reg_byte_t d, input logic be);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= {3'b000, be};
    avs_write <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task bus_rd(input logic [7:0] a, input reg_byte_t e);
    @(posedge sys_clk);
    exp_q.push_back({24'h0, e});
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
  endtask

  // Counts high cycles and rising edges of both LEDs over one 256-cycle span.
  task measure;
    logic pa, pb;
    repeat (4) @(posedge sys_clk);
    {ha, hb, ra, rb} = 128'h0;
    pa = led_a_q;
    pb = led_b_q;
    repeat (256)
    begin
      @(posedge sys_clk);
      ha += led_a_q;
      hb += led_b_q;
      ra += (led_a_q && !pa);
      rb += (led_b_q && !pb);
      pa = led_a_q;
      pb = led_b_q;
    end
  endtask

  // Each read answer is compared against the oldest expectation.
  always @(posedge sys_clk)
  begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
    begin
      check_val(avs_readdata, exp_q.pop_front());
    end
  end

  // The run needs about 9000 cycles; a hang is cut off well beyond that.
  initial
  begin
    #300000;
    err_count++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 4; i++) bus_rd(IDX[i], 8'h00);
    bus_rd(`IDX_REVISION, {4'h0, REV});
    bus_rd(8'h7f, 8'h00);
    // Random data, then a write with the byte lane disabled that must not land.
    for (int i = 0; i < 4; i++)
    begin
      val[i] = 8'($random(seed)) & MSK[i];
      bus_wr(IDX[i], val[i] | ~MSK[i], 1'b1);
      bus_rd(IDX[i], val[i]);
      bus_wr(IDX[i], ~val[i], 1'b0);
      bus_rd(IDX[i], val[i]);
    end
    bus_wr(`IDX_REVISION, 8'hff, 1'b1);
    bus_rd(`IDX_REVISION, {4'h8, REV});
    check_val({31'h0, boot_read_en_q}, 32'h1);
    // A shorter interval on LED a shows twice in the span.
    bus_wr(`IDX_LED_INTERVAL, 8'h2c, 1'b1);
    bus_wr(`IDX_LED_SHAPE, 8'h00, 1'b1);
    measure();
    check_val(ra, 2);
    check_val(ha, 2 * TICK);
    bus_wr(`IDX_LED_INTERVAL, 8'h2d, 1'b1);
    for (int w = 0; w < 4; w++)
    begin
      for (int d = 0; d < 2; d++)
      begin
        bus_wr(`IDX_LED_SHAPE, {2'b00, 1'(1 - d), 1'(d), 2'(3 - w), 2'(w)}, 1'b1);
        measure();
        check_val(ha, (1 + d) * (TICK << w));
        check_val(ra, 1 + d);
        check_val(hb, (2 - d) * (TICK << (3 - w)));
        check_val(rb, 2 - d);
      end
    end
    bus_wr(`IDX_LED_INTERVAL, 8'h00, 1'b1);
    measure();
    check_val(ha + hb, 0);
    // Pin level, then the pin carries the PWM over one full period, then the pin released.
    bus_wr(`IDX_GPIO_ROUTE, 8'h03, 1'b1);
    repeat (3) @(posedge sys_clk);
    check_val({30'h0, gpio_oe_n_q, gpio_out_q}, 32'h1);
    // New rate and duty apply only at a period end, so the longest old period is waited out.
    val[2] = 8'($random(seed)) | 8'h01;
    bus_wr(`IDX_PWM_RATE_SELECT, 8'h01, 1'b1);
    bus_wr(`IDX_PWM_DUTY, val[2], 1'b1);
    bus_wr(`IDX_GPIO_ROUTE, 8'h07, 1'b1);
    repeat (5200) @(posedge sys_clk);
    {ha, hb, ra} = 96'h0;
    rb = pwm_q;
    repeat (PWM_SLOT * 2 * 256)
    begin
      @(posedge sys_clk);
      ha += pwm_q;
      hb += gpio_out_q;
      ra += (pwm_q && !rb);
      rb = pwm_q;
    end
    check_val(ha, val[2] * (PWM_SLOT << 1));
    check_val(ra, 1);
    check_val(hb, val[2] * (PWM_SLOT << 1));
    check_val({31'h0, gpio_oe_n_q}, 32'h0);
    bus_wr(`IDX_GPIO_ROUTE, 8'h01, 1'b1);
    repeat (3) @(posedge sys_clk);
    check_val({30'h0, gpio_oe_n_q, gpio_out_q}, 32'h3);
    // LED b blinking, LED a held on and the pin driven, so the general reset has something to clear.
    bus_wr(`IDX_LED_INTERVAL, 8'h09, 1'b1);
    bus_wr(`IDX_GPIO_ROUTE, 8'h03, 1'b1);
    // General reset spares the scratch byte and the boot read enable.
    gen_rst <= 1'b1;
    @(posedge sys_clk);
    gen_rst <= 1'b0;
    for (int i = 0; i < 4; i++) bus_rd(IDX[i], (i == 3) ? val[3] : 8'h00);
    bus_rd(`IDX_REVISION, {4'h8, REV});
    bus_rd(`IDX_GPIO_ROUTE, 8'h00);
    bus_rd(`IDX_LED_INTERVAL, 8'h00);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    bus_rd(`IDX_SCRATCH, 8'h00);
    bus_rd(`IDX_REVISION, {4'h0, REV});
    repeat (4) @(posedge sys_clk);
    complete_run();
  end
endmodule
